// ===== src/tbdv_top.sv
// time base interrupt and divider output with axi4-lite registers
`timescale 1ns/1ps
`default_nettype none
module tbdv_top
  import tbdv_pkg::*;
#(
  parameter int unsigned ADDR_W = TBDV_ADDR_W,
  parameter int unsigned CHAIN_W = TBDV_CHAIN_W
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // axi4-lite write address
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  // axi4-lite write data
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // axi4-lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read address
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  // axi4-lite read data
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // clock source and operating mode
  input wire logic lowFreqClk,
  input wire logic lowFreqMode,
  // outputs
  output logic divoutPinN,
  output logic irq
);

  // tap decoding, shared by the timebase and the divider output
  function automatic logic pickTap(
    input logic [CHAIN_W-1:0] chain,
    input logic [4:0] idx
  );
    pickTap = chain[idx];
  endfunction

  function automatic logic isMapped(input logic [ADDR_W-1:0] addr);
    isMapped = (addr == TBDV_OFS_CTRL) || (addr == TBDV_OFS_STATUS) ||
               (addr == TBDV_OFS_MASK);
  endfunction

  // a write lands only on its own word and only with byte lane 0
  function automatic logic wrHit(
    input logic [ADDR_W-1:0] addr,
    input logic [ADDR_W-1:0] ofs,
    input logic strobe
  );
    wrHit = (addr == ofs) && strobe;
  endfunction

  // register state
  logic [7:0] ctrl_r;
  logic [7:0] ctrl_nxt;
  logic [0:0] status_r;
  logic [0:0] status_nxt;
  logic [0:0] mask_r;
  logic [0:0] mask_nxt;

  // write channel state
  logic awHeld_r;
  logic [ADDR_W-1:0] awAddr_r;
  logic wHeld_r;
  logic [31:0] wData_r;
  logic [3:0] wStrb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic doWrite;

  // read channel state
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic readTaken;
  logic statusRead;

  // timebase and divider state
  logic [CHAIN_W-1:0] chainCount;
  logic lowSrc;
  logic divoutEnable;
  logic [1:0] divoutRateSelect;
  logic timebaseIrqEnable;
  logic [2:0] timebaseRateSelect;
  logic tbTap;
  logic dvTap;
  logic tbCodeOk;
  logic tbTapPrev_r;
  logic tbArmed_r;
  logic timebaseInterrupt;
  logic divoutPinN_r;
  logic irq_r;

  // control fields
  assign divoutEnable = ctrl_r[TBDV_DIVOUT_EN_BIT];
  assign divoutRateSelect = ctrl_r[TBDV_DIVOUT_RATE_LSB +: 2];
  assign timebaseIrqEnable = ctrl_r[TBDV_TB_EN_BIT];
  assign timebaseRateSelect = ctrl_r[TBDV_TB_RATE_LSB +: 3];

  // the low clock feeds the chain in low modes or when selected
  assign lowSrc = lowFreqMode | ctrl_r[TBDV_SRC_SEL_BIT];

  // one shared chain keeps the timebase and the divider output in phase
  tbdv_divider_chain #(
    .CHAIN_W(CHAIN_W)
  ) u_chain (
    .mclk(mclk),
    .resetn(resetn),
    .lowFreqClk(lowFreqClk),
    .lowSrc(lowSrc),
    .chainCount(chainCount)
  );

  // tap selection
  always_comb
  begin
    if (lowSrc)
      tbTap = pickTap(chainCount, TBDV_TB_LF_TAP[timebaseRateSelect]);
    else
      tbTap = pickTap(chainCount, TBDV_TB_HF_TAP[timebaseRateSelect]);
  end

  always_comb
  begin
    if (lowSrc)
      dvTap = pickTap(chainCount, TBDV_DV_LF_TAP[divoutRateSelect]);
    else
      dvTap = pickTap(chainCount, TBDV_DV_HF_TAP[divoutRateSelect]);
  end

  // fast codes have no tap in the low-frequency modes
  assign tbCodeOk = !lowFreqMode || (timebaseRateSelect <= TBDV_LOW_MODE_MAX_CODE);

  // armed only after one enabled cycle, so on arming the tap history
  // belongs to the rate written with the enable; a stale sample of
  // the old rate would otherwise fake an edge
  always_ff @(posedge mclk)
  begin
    if (!resetn)
      tbArmed_r <= 1'b0;
    else
      tbArmed_r <= timebaseIrqEnable;
  end

  // tap history runs always; its reset value matches a cleared chain
  always_ff @(posedge mclk)
  begin
    if (!resetn)
      tbTapPrev_r <= 1'b0;
    else
      tbTapPrev_r <= tbTap;
  end

  // one pulse per falling edge; the first may come early since
  // the chain keeps its phase across enables
  assign timebaseInterrupt = timebaseIrqEnable & tbArmed_r & tbCodeOk &
                             tbTapPrev_r & ~tbTap;

  // divider pin is active low and idles high while disabled
  always_ff @(posedge mclk)
  begin
    if (!resetn)
      divoutPinN_r <= 1'b1;
    else if (divoutEnable)
      divoutPinN_r <= ~dvTap;
    else
      divoutPinN_r <= 1'b1;
  end

  assign divoutPinN = divoutPinN_r;

  // axi write path: address and data are held independently
  // bvalid blocks both readies so a new write cannot pass its response
  assign awready = !awHeld_r && !bvalid_r;
  assign wready = !wHeld_r && !bvalid_r;
  assign doWrite = awHeld_r && wHeld_r && !bvalid_r;

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      awHeld_r <= 1'b0;
      awAddr_r <= '0;
    end
    else if (awvalid && awready)
    begin
      awHeld_r <= 1'b1;
      awAddr_r <= awaddr;
    end
    else if (doWrite)
      awHeld_r <= 1'b0;
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      wHeld_r <= 1'b0;
      wData_r <= '0;
      wStrb_r <= '0;
    end
    else if (wvalid && wready)
    begin
      wHeld_r <= 1'b1;
      wData_r <= wdata;
      wStrb_r <= wstrb;
    end
    else if (doWrite)
      wHeld_r <= 1'b0;
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      bvalid_r <= 1'b0;
      bresp_r <= TBDV_RESP_OKAY;
    end
    else if (doWrite)
    begin
      bvalid_r <= 1'b1;
      bresp_r <= isMapped(awAddr_r) ? TBDV_RESP_OKAY : TBDV_RESP_SLVERR;
    end
    else if (bready)
      bvalid_r <= 1'b0;
  end

  assign bvalid = bvalid_r;
  assign bresp = bresp_r;

  // rate rules are left to software; a rate changed while enabled is taken as is
  // control register: whole byte taken in one write, so a rate and
  // its enable are never seen half-updated
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    if (doWrite && wrHit(awAddr_r, TBDV_OFS_CTRL, wStrb_r[0]))
      ctrl_nxt = wData_r[7:0];
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
      ctrl_r <= TBDV_CTRL_RESET;
    else
      ctrl_r <= ctrl_nxt;
  end

  always_comb
  begin
    mask_nxt = mask_r;
    if (doWrite && wrHit(awAddr_r, TBDV_OFS_MASK, wStrb_r[0]))
      mask_nxt = wData_r[TBDV_TB_EVENT_BIT +: 1];
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
      mask_r <= TBDV_MASK_RESET;
    else
      mask_r <= mask_nxt;
  end

  // axi read path
  // data is captured at the address edge, so status gives its pre-clear value
  assign arready = !rvalid_r;
  assign readTaken = arvalid && arready;
  assign statusRead = readTaken && (araddr == TBDV_OFS_STATUS);

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= TBDV_RESP_OKAY;
    end
    else if (readTaken)
    begin
      rvalid_r <= 1'b1;
      rresp_r <= isMapped(araddr) ? TBDV_RESP_OKAY : TBDV_RESP_SLVERR;
      case (araddr)
        TBDV_OFS_CTRL: rdata_r <= {24'h000000, ctrl_r};
        TBDV_OFS_STATUS: rdata_r <= {31'h00000000, status_r};
        TBDV_OFS_MASK: rdata_r <= {31'h00000000, mask_r};
        default: rdata_r <= 32'h00000000;
      endcase
    end
    else if (rready)
      rvalid_r <= 1'b0;
  end

  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;

  // sticky event, cleared by reading; a new event beats the clear
  always_comb
  begin
    status_nxt = status_r;
    if (statusRead)
      status_nxt = 1'b0;
    if (timebaseInterrupt)
      status_nxt = 1'b1;
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
      status_r <= TBDV_STATUS_RESET;
    else
      status_r <= status_nxt;
  end

  // registered so the line never glitches; costs one cycle
  always_ff @(posedge mclk)
  begin
    if (!resetn)
      irq_r <= 1'b0;
    else
      irq_r <= |(status_r & mask_r);
  end

  assign irq = irq_r;

endmodule
`default_nettype wire

// ===== src/tbdv_pkg.sv
// constants shared by the time base and divider output block
// Notes on behaviour
// - rate and enable in one write start
// - three-bit rate; low modes allow codes 0-1
// - interrupt on every falling edge of tap
// - divider chain is never reset by writes
// - enabled divider output drives 50% square wave
// - bit 7 enables divider output, read/write
// - two-bit divider output rate selects tap
// - control register resets to zero, fixed layout
// - high-frequency timebase taps 2^23 down to 2^9
// - low-frequency timebase taps 2^15 down to 2
package tbdv_pkg;

  localparam int unsigned TBDV_ADDR_W = 4;
  localparam int unsigned TBDV_CHAIN_W = 24;

  // register byte offsets
  localparam logic [3:0] TBDV_OFS_CTRL = 4'h0;
  localparam logic [3:0] TBDV_OFS_STATUS = 4'h4;
  localparam logic [3:0] TBDV_OFS_MASK = 4'h8;

  // control register layout
  localparam int unsigned TBDV_DIVOUT_EN_BIT = 7;
  localparam int unsigned TBDV_DIVOUT_RATE_LSB = 5;
  localparam int unsigned TBDV_SRC_SEL_BIT = 4;
  localparam int unsigned TBDV_TB_EN_BIT = 3;
  localparam int unsigned TBDV_TB_RATE_LSB = 0;
  localparam logic [7:0] TBDV_CTRL_RESET = 8'h00;

  // status and mask layout
  localparam int unsigned TBDV_TB_EVENT_BIT = 0;
  localparam logic [0:0] TBDV_STATUS_RESET = 1'h0;
  localparam logic [0:0] TBDV_MASK_RESET = 1'h0;

  // highest timebase code usable in the low-frequency modes
  localparam logic [2:0] TBDV_LOW_MODE_MAX_CODE = 3'h1;

  // chain bit index for a divide by 2^n is n-1
  localparam logic [4:0] TBDV_TB_HF_TAP [0:7] =
    '{5'h16, 5'h14, 5'h0f, 5'h0d, 5'h0c, 5'h0b, 5'h0a, 5'h08};
  localparam logic [4:0] TBDV_TB_LF_TAP [0:7] =
    '{5'h0e, 5'h0c, 5'h07, 5'h05, 5'h04, 5'h03, 5'h02, 5'h00};
  localparam logic [4:0] TBDV_DV_HF_TAP [0:3] = '{5'h0c, 5'h0b, 5'h0a, 5'h09};
  localparam logic [4:0] TBDV_DV_LF_TAP [0:3] = '{5'h04, 5'h03, 5'h02, 5'h01};

  // axi responses
  localparam logic [1:0] TBDV_RESP_OKAY = 2'h0;
  localparam logic [1:0] TBDV_RESP_SLVERR = 2'h2;

endpackage

// ===== src/tbdv_divider_chain.sv
// free-running divider chain with low-frequency clock synchroniser
`timescale 1ns/1ps
`default_nettype none
module tbdv_divider_chain
  import tbdv_pkg::*;
#(
  parameter int unsigned CHAIN_W = TBDV_CHAIN_W
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // source
  input wire logic lowFreqClk,
  input wire logic lowSrc,
  // chain state
  output logic [CHAIN_W-1:0] chainCount
);

  logic lfSync1_r;
  logic lfSync2_r;
  logic lfSync3_r;
  logic lfTick;

  // low clock arrives from a pin, so two flops before use
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      lfSync1_r <= 1'b0;
      lfSync2_r <= 1'b0;
      lfSync3_r <= 1'b0;
    end
    else
    begin
      lfSync1_r <= lowFreqClk;
      lfSync2_r <= lfSync1_r;
      lfSync3_r <= lfSync2_r;
    end
  end

  assign lfTick = lfSync2_r & ~lfSync3_r;

  // runs regardless of either enable; writes never clear it
  always_ff @(posedge mclk)
  begin
    if (!resetn)
      chainCount <= '0;
    else if (!lowSrc || lfTick)
      chainCount <= chainCount + 1'b1;
  end

endmodule
`default_nettype wire

// ===== src/unused_note_placeholder.sv
// intentionally minimal: no content beyond a package-free marker
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ===== bench/tbdv_props.sv
// checker for the time base block ports
`timescale 1ns/1ps
`default_nettype none
module tbdv_props
  import tbdv_pkg::*;
#(
  parameter int unsigned ADDR_W = TBDV_ADDR_W
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // bus
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready,
  // outputs
  input wire logic divoutPinN,
  input wire logic irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  sequence wr_take;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence rd_take;
    arvalid && arready;
  endsequence
  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = (a == TBDV_OFS_CTRL) || (a == TBDV_OFS_STATUS) || (a == TBDV_OFS_MASK);
  endfunction
  a_write_resp_code: assert property (wr_take |-> ##2 bvalid && bresp ==
    (mapped($past(awaddr, 2)) ? TBDV_RESP_OKAY : TBDV_RESP_SLVERR))
    else $error("write response wrong");
  a_read_resp_code: assert property (rd_take |=> rvalid && rresp ==
    (mapped($past(araddr)) ? TBDV_RESP_OKAY : TBDV_RESP_SLVERR))
    else $error("read response wrong");
  a_unmapped_zero: assert property (rd_take ##0 !mapped(araddr) |=> rdata == 0)
    else $error("unmapped read not zero");
  a_b_release: assert property (bvalid && bready |=> !bvalid)
    else $error("bvalid stuck");
  a_r_release: assert property (rvalid && rready |=> !rvalid)
    else $error("rvalid stuck");
  a_ar_blocked: assert property (rvalid |-> !arready)
    else $error("arready while rvalid");
  a_aw_blocked: assert property (bvalid |-> !awready && !wready)
    else $error("write ready while bvalid");
  a_pin_half: assert property ($rose(divoutPinN) |=> divoutPinN[*8])
    else $error("divider output half period short");
  a_irq_clear: assert property (rd_take ##0 araddr == TBDV_OFS_STATUS |-> ##[2:4] !irq)
    else $error("irq not cleared by status read");
endmodule
bind tbdv_top tbdv_props #(.ADDR_W(ADDR_W)) u_props (.mclk, .resetn, .awaddr, .awvalid,
  .awready, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
  .rdata, .rresp, .rvalid, .rready, .divoutPinN, .irq);
`default_nettype wire

// ===== bench/tbdv_buzzer.sv
// buzzer model measuring the divider output half periods
`timescale 1ns/1ps
`default_nettype none
module tbdv_buzzer
(
  // clock
  input wire logic mclk,
  // pin
  input wire logic divoutPinN,
  // measurements
  output logic [15:0] hiLen,
  output logic [15:0] loLen,
  output logic [7:0] edges
);
  logic [15:0] cnt = 16'h1;
  logic last = 1'b1;
  initial
  begin
    hiLen = 16'h0;
    loLen = 16'h0;
    edges = 8'h0;
  end
  // a buzzer only listens, so it never loads the pin
  always @(posedge mclk)
  begin
    last <= divoutPinN;
    cnt <= (divoutPinN !== last) ? 16'h1 : cnt + 16'h1;
    if (divoutPinN !== last)
    begin
      edges <= edges + 8'h1;
      if (last)
        hiLen <= cnt;
      else
        loLen <= cnt;
    end
  end
endmodule
`default_nettype wire

// ===== bench/testbench.sv
// self-checking bench for the time base block
`timescale 1ns/1ps
`default_nettype none
module testbench
  import tbdv_pkg::*;
;
  localparam int LfHalf = 4;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic [3:0] awaddr = 4'h0;
  logic [3:0] araddr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic lowFreqClk = 1'b0, lowFreqMode = 1'b0;
  logic [31:0] rdata;
  logic [1:0] bresp, rresp;
  logic awready, wready, bvalid, arready, rvalid, divoutPinN, irq;
  logic [15:0] hiLen, loLen;
  logic [7:0] edges, e0;
  logic [31:0] v;
  int error_cnt = 0, n_compared = 0, cyc = 0, t0, i, c;
  tbdv_top dut (.mclk, .resetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .lowFreqClk, .lowFreqMode, .divoutPinN, .irq);
  tbdv_buzzer buzzer (.mclk, .divoutPinN, .hiLen, .loLen, .edges);
  always #10 mclk = ~mclk;
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc % LfHalf == 0)
      lowFreqClk <= ~lowFreqClk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic ta, tw;
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(negedge mclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      @(posedge mclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end while ((awvalid && !ta) || (wvalid && !tw));
    while (bvalid !== 1'b1) @(negedge mclk);
    @(posedge mclk);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge mclk); while (arready !== 1'b1);
    @(posedge mclk);
    arvalid <= 1'b0;
    do @(negedge mclk); while (rvalid !== 1'b1);
    d = rdata;
    @(posedge mclk);
    rready <= 1'b0;
  endtask
  task automatic rdChk(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(d, e);
  endtask
  // the settle wait keeps a just-cleared irq from being taken as new
  task automatic waitIrq;
    repeat (3) @(posedge mclk);
    repeat (2000) if (irq !== 1'b1) @(negedge mclk);
  endtask
  task finish_test;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    for (i = 0; i < 4; i++)
      rdChk(4'(i * 4), 32'h0);
    wr(4'hc, 32'h1);
    wr(4'h0, 32'hffffff77);
    rdChk(4'h0, 32'h77);
    wr(4'h0, 32'hf7);
    rdChk(4'h0, 32'hf7);
    wr(4'h0, 32'h77);
    wr(4'h0, 32'h0f);
    repeat (600) @(posedge mclk);
    chk(irq, 32'h0);
    rdChk(4'h4, 32'h1);
    wr(4'h0, 32'h07);
    rd(4'h4, v);
    rdChk(4'h4, 32'h0);
    wstrb <= 4'he;
    wr(4'h0, 32'h00);
    wstrb <= 4'hf;
    rdChk(4'h0, 32'h07);
    wr(4'h8, 32'h1);
    wr(4'h0, 32'h0f);
    t0 = cyc;
    waitIrq();
    chk(32'(cyc - t0 <= 520), 32'h1);
    rd(4'h4, v);
    waitIrq();
    t0 = cyc;
    rd(4'h4, v);
    waitIrq();
    chk(32'(cyc - t0), 32'd512);
    wr(4'h0, 32'h07);
    rd(4'h4, v);
    lowFreqMode <= 1'b1;
    wr(4'h0, 32'h0f);
    repeat (300) @(posedge mclk);
    rdChk(4'h4, 32'h0);
    wr(4'h0, 32'h07);
    lowFreqMode <= 1'b0;
    wr(4'h0, 32'h1f);
    waitIrq();
    rd(4'h4, v);
    waitIrq();
    t0 = cyc;
    rd(4'h4, v);
    waitIrq();
    chk(32'(cyc - t0), 32'(4 * LfHalf));
    wr(4'h0, 32'h17);
    rd(4'h4, v);
    for (i = 0; i < 5; i++)
    begin
      lowFreqMode <= (i == 4);
      c = (i == 4) ? 3 : i;
      wr(4'h0, 32'(c << 5));
      wr(4'h0, 32'(c << 5 | 8'h80));
      e0 = edges;
      repeat (20000) if (8'(edges - e0) < 8'h4) @(posedge mclk);
      chk(hiLen, (i == 4) ? 4 * LfHalf : 1 << (12 - i));
      chk(loLen, (i == 4) ? 4 * LfHalf : 1 << (12 - i));
      wr(4'h0, 32'(c << 5));
      repeat (3) @(posedge mclk);
      chk(divoutPinN, 32'h1);
    end
    finish_test();
  end
  initial
  begin
    repeat (100000) @(posedge mclk);
    error_cnt++;
    finish_test();
  end
endmodule
`default_nettype wire
